// File: hdl/pmvc_pkg.sv
// Package for the output-voltage configuration command block
package pmvc_pkg;

  // Command codes
  localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CODE_STORE_DEFAULT = 8'h11;
  localparam logic [7:0] CODE_RESTORE_DEFAULT = 8'h12;
  localparam logic [7:0] CODE_STORE_USER = 8'h15;
  localparam logic [7:0] CODE_RESTORE_USER = 8'h16;
  localparam logic [7:0] CODE_FORMAT_MODE = 8'h20;
  localparam logic [7:0] CODE_SETPOINT = 8'h21;
  localparam logic [7:0] CODE_TRIM = 8'h22;
  localparam logic [7:0] CODE_CAL = 8'h23;
  localparam logic [7:0] CODE_CEILING = 8'h24;
  localparam logic [7:0] CODE_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] CODE_MARGIN_LOW = 8'h26;
  localparam logic [7:0] CODE_SLEW = 8'h27;
  localparam logic [7:0] CODE_DROOP = 8'h28;
  localparam logic [7:0] CODE_DUTY = 8'h32;

  // Configuration word slots
  localparam int NUM_CFG = 9;
  localparam logic [3:0] IDX_SETPOINT = 4'h0;
  localparam logic [3:0] IDX_TRIM = 4'h1;
  localparam logic [3:0] IDX_CAL = 4'h2;
  localparam logic [3:0] IDX_CEILING = 4'h3;
  localparam logic [3:0] IDX_MARGIN_HIGH = 4'h4;
  localparam logic [3:0] IDX_MARGIN_LOW = 4'h5;
  localparam logic [3:0] IDX_SLEW = 4'h6;
  localparam logic [3:0] IDX_DROOP = 4'h7;
  localparam logic [3:0] IDX_DUTY = 4'h8;

  // Output format byte fields
  localparam logic [2:0] FMT_LINEAR = 3'h0;
  localparam logic [2:0] FMT_VID = 3'h1;
  localparam logic [2:0] FMT_DIRECT = 3'h2;
  localparam logic [4:0] FMT_DIRECT_PARAM = 5'h00;

  // Margin selection from the operation command
  localparam logic [1:0] MARGIN_NOMINAL = 2'h0;
  localparam logic [1:0] MARGIN_LOW = 2'h1;
  localparam logic [1:0] MARGIN_HIGH = 2'h2;

  // Security levels
  localparam logic [1:0] SEC_LEVEL0 = 2'h0;
  localparam logic [1:0] SEC_LEVEL1 = 2'h1;

  // Ceiling and duty limits, linear word layout
  localparam int CEIL_PCT_NUM = 110;
  localparam int CEIL_PCT_DEN = 100;
  localparam int DUTY_MAX_PCT = 100;
  localparam int LIN_MANT_MSB = 10;
  localparam int LIN_EXP_LSB = 11;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [15:0] FULL_WORD = 16'hffff;

  typedef enum logic [1:0] {
    PMVC_SEND_BYTE,
    PMVC_READ_BYTE,
    PMVC_WRITE_WORD,
    PMVC_READ_WORD
  } pmvc_kind_t;

  typedef struct packed {
    pmvc_kind_t kind;
    logic [7:0] code;
    logic [15:0] data;
  } pmvc_cmd_t;

  typedef enum logic [2:0] {
    PMVC_WAIT0,
    PMVC_WAIT1,
    PMVC_FACTORY,
    PMVC_USER_LOAD,
    PMVC_RUN
  } pmvc_state_t;

endpackage : pmvc_pkg

// File: hdl/pmvc_target.sv
// Effective output target: margin select, offsets and ceiling clamp
`timescale 1ns/1ps
module pmvc_target
  import pmvc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] margin_sel,
  input wire logic [15:0] setpoint,
  input wire logic [15:0] margin_high,
  input wire logic [15:0] margin_low,
  input wire logic [15:0] trim,
  input wire logic [15:0] cal,
  input wire logic [15:0] ceiling,
  output logic [15:0] target
);

  logic [15:0] target_r;
  logic [15:0] target_nxt;
  logic [15:0] base;
  logic signed [17:0] sum;

  always_comb begin
    case (margin_sel)
      MARGIN_LOW: base = margin_low;
      MARGIN_HIGH: base = margin_high;
      default: base = setpoint;
    endcase
    sum = $signed({2'h0, base}) + 18'($signed(trim))
        + 18'($signed(cal));
    if (sum < 0) begin
      target_nxt = ZERO_WORD;
    end else if (sum > $signed({2'h0, ceiling})) begin
      target_nxt = ceiling;
    end else begin
      target_nxt = sum[15:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target_r <= ZERO_WORD;
    end else begin
      target_r <= target_nxt;
    end
  end

  assign target = target_r;

endmodule : pmvc_target

// File: hdl/pmvc_top.sv
// Output-voltage configuration command interpreter with config stores
//
// Summary of operation
// - Send-byte 0x03 clears held fault status bits, except bits with a fault event in the same cycle.
// - Send-byte 0x11 copies the whole configuration into the default store.
// - Send-byte 0x12 reloads the working configuration from default store.
// - Send-byte 0x15 saves words modified since last restore into user store.
// - 0x16 restores the user store; also done automatically at power-up.
// - User restore values overwrite values from an earlier default restore.
// - Completing a user restore sets security level 1.
// - Format byte bits 7:5 give mode: linear, VID or direct.
// - Format bits 4:0 hold exponent, VID code, or zero in direct mode.
// - Word 0x21 sets nominal target, starts transition; strap gives default.
// - Word 0x22 is a signed offset added to the output target.
// - Word 0x23 is a second signed offset, like the trim word.
// - Targets above the ceiling word 0x24 are clamped to the ceiling.
// - Ceiling writes above 110 percent of the strap voltage are clamped; restores are not.
// - Word 0x25 is the margin-high target; strap gives its default.
// - Word 0x26 is the margin-low target; strap gives its default.
// - Linear word 0x27 sets slew rate for margin and setpoint moves.
// - Linear word 0x28 sets the droop load-line slope.
// - Linear word 0x32 limits duty cycle within 0 to 100 percent.
// - Margin select 01 picks low, 10 picks high, else nominal.
`timescale 1ns/1ps
module pmvc_top
  import pmvc_pkg::*;
#(
  parameter int FAULT_BITS = 8,
  parameter logic [2:0] FMT_MODE = FMT_LINEAR,
  parameter logic [4:0] FMT_PARAM = 5'h17,
  parameter logic [15:0] SLEW_DEFAULT = 16'h0000,
  parameter logic [15:0] DROOP_DEFAULT = 16'h0000,
  parameter logic [15:0] DUTY_DEFAULT = 16'h0000
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic STORE_RESETN,
  input wire logic CMD_VALID,
  input wire pmvc_cmd_t CMD,
  output logic RD_VALID,
  output logic [15:0] RD_DATA,
  output logic CMD_ERR,
  output logic CONFIG_READY,
  input wire logic [15:0] VOLTAGE_SELECT_STRAP,
  input wire logic [1:0] MARGIN_SEL,
  input wire logic [FAULT_BITS-1:0] FAULT_EVENT,
  output logic [FAULT_BITS-1:0] FAULT_STATUS,
  output logic [1:0] SECURITY_LEVEL,
  output logic TRANSITION_START,
  output logic [15:0] TARGET_VOLTAGE,
  output logic [15:0] SLEW_RATE,
  output logic [15:0] DROOP_SLOPE,
  output logic [15:0] DUTY_LIMIT
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [15:0] ceil_limit(input logic [15:0] s);
    logic [22:0] q;
    q = (23'(s) * 23'(CEIL_PCT_NUM)) / 23'(CEIL_PCT_DEN);
    ceil_limit = (q > 23'(FULL_WORD)) ? FULL_WORD : q[15:0];
  endfunction : ceil_limit

  // Linear word: signed 11-bit mantissa, signed 5-bit exponent
  function automatic logic duty_ok(input logic [15:0] w);
    logic signed [10:0] m;
    logic signed [4:0] e;
    logic [31:0] mag;
    logic [4:0] sh;
    m = w[LIN_MANT_MSB:0];
    e = w[15:LIN_EXP_LSB];
    mag = {21'h0, m};
    sh = 5'h00;
    if (m < 0) begin
      duty_ok = 1'b0;
    end else if (e >= 0) begin
      duty_ok = (mag << e) <= 32'(DUTY_MAX_PCT);
    end else begin
      sh = 5'(-e);
      duty_ok = mag <= (32'(DUTY_MAX_PCT) << sh);
    end
  endfunction : duty_ok

  // Returns {valid, slot} for word-sized codes
  function automatic logic [4:0] cfg_slot(input logic [7:0] code);
    case (code)
      CODE_SETPOINT: cfg_slot = {1'b1, IDX_SETPOINT};
      CODE_TRIM: cfg_slot = {1'b1, IDX_TRIM};
      CODE_CAL: cfg_slot = {1'b1, IDX_CAL};
      CODE_CEILING: cfg_slot = {1'b1, IDX_CEILING};
      CODE_MARGIN_HIGH: cfg_slot = {1'b1, IDX_MARGIN_HIGH};
      CODE_MARGIN_LOW: cfg_slot = {1'b1, IDX_MARGIN_LOW};
      CODE_SLEW: cfg_slot = {1'b1, IDX_SLEW};
      CODE_DROOP: cfg_slot = {1'b1, IDX_DROOP};
      CODE_DUTY: cfg_slot = {1'b1, IDX_DUTY};
      default: cfg_slot = {1'b0, IDX_SETPOINT};
    endcase
  endfunction : cfg_slot

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [15:0] strap_s1_r;
  logic [15:0] strap_s2_r;
  logic [15:0] strap_cap_r;
  logic [15:0] strap_cap_nxt;
  pmvc_state_t state_r;
  pmvc_state_t state_nxt;
  logic [15:0] cfg_r [NUM_CFG];
  logic [15:0] cfg_nxt [NUM_CFG];
  logic [NUM_CFG-1:0] mod_r;
  logic [NUM_CFG-1:0] mod_nxt;
  logic [15:0] dflt_r [NUM_CFG];
  logic [15:0] dflt_nxt [NUM_CFG];
  logic [NUM_CFG-1:0] dflt_vld_r;
  logic [NUM_CFG-1:0] dflt_vld_nxt;
  logic [15:0] usr_r [NUM_CFG];
  logic [15:0] usr_nxt [NUM_CFG];
  logic [NUM_CFG-1:0] usr_vld_r;
  logic [NUM_CFG-1:0] usr_vld_nxt;
  logic [FAULT_BITS-1:0] fault_r;
  logic [FAULT_BITS-1:0] fault_nxt;
  logic [1:0] sec_r;
  logic [1:0] sec_nxt;
  logic rd_valid_r;
  logic rd_valid_nxt;
  logic [15:0] rd_data_r;
  logic [15:0] rd_data_nxt;
  logic err_r;
  logic err_nxt;
  logic trans_r;
  logic trans_nxt;
  logic clear_faults;
  logic do_user_load;
  logic [4:0] slot;
  logic [3:0] idx;
  logic [15:0] ceil_max;

  assign slot = cfg_slot(CMD.code);
  assign idx = slot[3:0];
  assign ceil_max = ceil_limit(strap_cap_r);

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchroniser

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      strap_s1_r <= ZERO_WORD;
      strap_s2_r <= ZERO_WORD;
    end else begin
      strap_s1_r <= VOLTAGE_SELECT_STRAP;
      strap_s2_r <= strap_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and configuration next state

  always_comb begin
    state_nxt = state_r;
    strap_cap_nxt = strap_cap_r;
    mod_nxt = mod_r;
    dflt_vld_nxt = dflt_vld_r;
    usr_vld_nxt = usr_vld_r;
    sec_nxt = sec_r;
    rd_valid_nxt = 1'b0;
    rd_data_nxt = rd_data_r;
    err_nxt = 1'b0;
    trans_nxt = 1'b0;
    clear_faults = 1'b0;
    do_user_load = 1'b0;
    for (int i = 0; i < NUM_CFG; i++) begin
      cfg_nxt[i] = cfg_r[i];
      dflt_nxt[i] = dflt_r[i];
      usr_nxt[i] = usr_r[i];
    end
    case (state_r)
      PMVC_WAIT0: state_nxt = PMVC_WAIT1;
      PMVC_WAIT1: state_nxt = PMVC_FACTORY;
      PMVC_FACTORY: begin
        strap_cap_nxt = strap_s2_r;
        cfg_nxt[IDX_SETPOINT] = strap_s2_r;
        cfg_nxt[IDX_TRIM] = ZERO_WORD;
        cfg_nxt[IDX_CAL] = ZERO_WORD;
        cfg_nxt[IDX_CEILING] = ceil_limit(strap_s2_r);
        cfg_nxt[IDX_MARGIN_HIGH] = strap_s2_r;
        cfg_nxt[IDX_MARGIN_LOW] = strap_s2_r;
        cfg_nxt[IDX_SLEW] = SLEW_DEFAULT;
        cfg_nxt[IDX_DROOP] = DROOP_DEFAULT;
        cfg_nxt[IDX_DUTY] = DUTY_DEFAULT;
        state_nxt = PMVC_USER_LOAD;
      end
      PMVC_USER_LOAD: begin
        do_user_load = 1'b1;
        state_nxt = PMVC_RUN;
      end
      PMVC_RUN: begin
        if (CMD_VALID) begin
          case (CMD.code)
            CODE_CLEAR_FAULTS: begin
              if (CMD.kind == PMVC_SEND_BYTE) begin
                clear_faults = 1'b1;
              end else begin
                err_nxt = 1'b1;
              end
            end
            CODE_STORE_DEFAULT: begin
              if (CMD.kind == PMVC_SEND_BYTE) begin
                for (int i = 0; i < NUM_CFG; i++) begin
                  dflt_nxt[i] = cfg_r[i];
                end
                dflt_vld_nxt = '1;
              end else begin
                err_nxt = 1'b1;
              end
            end
            CODE_RESTORE_DEFAULT: begin
              if (CMD.kind == PMVC_SEND_BYTE) begin
                for (int i = 0; i < NUM_CFG; i++) begin
                  if (dflt_vld_r[i]) begin
                    cfg_nxt[i] = dflt_r[i];
                  end
                end
                mod_nxt = '0;
              end else begin
                err_nxt = 1'b1;
              end
            end
            CODE_STORE_USER: begin
              if (CMD.kind == PMVC_SEND_BYTE) begin
                for (int i = 0; i < NUM_CFG; i++) begin
                  if (mod_r[i]) begin
                    usr_nxt[i] = cfg_r[i];
                  end
                end
                usr_vld_nxt = usr_vld_r | mod_r;
              end else begin
                err_nxt = 1'b1;
              end
            end
            CODE_RESTORE_USER: begin
              if (CMD.kind == PMVC_SEND_BYTE) begin
                do_user_load = 1'b1;
              end else begin
                err_nxt = 1'b1;
              end
            end
            CODE_FORMAT_MODE: begin
              if (CMD.kind == PMVC_READ_BYTE) begin
                rd_valid_nxt = 1'b1;
                if (FMT_MODE == FMT_DIRECT) begin
                  rd_data_nxt = {8'h00, FMT_MODE, FMT_DIRECT_PARAM};
                end else begin
                  rd_data_nxt = {8'h00, FMT_MODE, FMT_PARAM};
                end
              end else begin
                err_nxt = 1'b1;
              end
            end
            default: begin
              if (!slot[4]) begin
                err_nxt = 1'b1;
              end else if (CMD.kind == PMVC_READ_WORD) begin
                rd_valid_nxt = 1'b1;
                rd_data_nxt = cfg_r[idx];
              end else if (CMD.kind != PMVC_WRITE_WORD) begin
                err_nxt = 1'b1;
              end else if (idx == IDX_DUTY && !duty_ok(CMD.data)) begin
                err_nxt = 1'b1;
              end else begin
                cfg_nxt[idx] = CMD.data;
                mod_nxt[idx] = 1'b1;
                if (idx == IDX_CEILING && CMD.data > ceil_max) begin
                  cfg_nxt[idx] = ceil_max;
                end
                if (idx == IDX_SETPOINT) begin
                  trans_nxt = 1'b1;
                end
              end
            end
          endcase
        end
      end
      default: state_nxt = PMVC_WAIT0;
    endcase
    if (CMD_VALID && state_r != PMVC_RUN) begin
      err_nxt = 1'b1;
    end
    if (do_user_load) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        if (usr_vld_r[i]) begin
          cfg_nxt[i] = usr_r[i];
        end
      end
      mod_nxt = '0;
      sec_nxt = SEC_LEVEL1;
    end
    fault_nxt = (clear_faults ? '0 : fault_r) | FAULT_EVENT;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working state registers

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= PMVC_WAIT0;
      strap_cap_r <= ZERO_WORD;
      mod_r <= '0;
      sec_r <= SEC_LEVEL0;
      rd_valid_r <= 1'b0;
      rd_data_r <= ZERO_WORD;
      err_r <= 1'b0;
      trans_r <= 1'b0;
      fault_r <= '0;
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg_r[i] <= ZERO_WORD;
      end
    end else begin
      state_r <= state_nxt;
      strap_cap_r <= strap_cap_nxt;
      mod_r <= mod_nxt;
      sec_r <= sec_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
      err_r <= err_nxt;
      trans_r <= trans_nxt;
      fault_r <= fault_nxt;
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg_r[i] <= cfg_nxt[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Retained stores, cleared only by their own erase reset

  always_ff @(posedge CORE_CLK or negedge STORE_RESETN) begin
    if (!STORE_RESETN) begin
      dflt_vld_r <= '0;
      usr_vld_r <= '0;
      for (int i = 0; i < NUM_CFG; i++) begin
        dflt_r[i] <= ZERO_WORD;
        usr_r[i] <= ZERO_WORD;
      end
    end else begin
      dflt_vld_r <= dflt_vld_nxt;
      usr_vld_r <= usr_vld_nxt;
      for (int i = 0; i < NUM_CFG; i++) begin
        dflt_r[i] <= dflt_nxt[i];
        usr_r[i] <= usr_nxt[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective target

  pmvc_target u_target (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .margin_sel(MARGIN_SEL),
    .setpoint(cfg_r[IDX_SETPOINT]),
    .margin_high(cfg_r[IDX_MARGIN_HIGH]),
    .margin_low(cfg_r[IDX_MARGIN_LOW]),
    .trim(cfg_r[IDX_TRIM]),
    .cal(cfg_r[IDX_CAL]),
    .ceiling(cfg_r[IDX_CEILING]),
    .target(TARGET_VOLTAGE)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign RD_VALID = rd_valid_r;
  assign RD_DATA = rd_data_r;
  assign CMD_ERR = err_r;
  assign CONFIG_READY = (state_r == PMVC_RUN);
  assign FAULT_STATUS = fault_r;
  assign SECURITY_LEVEL = sec_r;
  assign TRANSITION_START = trans_r;
  assign SLEW_RATE = cfg_r[IDX_SLEW];
  assign DROOP_SLOPE = cfg_r[IDX_DROOP];
  assign DUTY_LIMIT = cfg_r[IDX_DUTY];

endmodule : pmvc_top

// File: verification/pmvc_chk.sv
// Assertion checker for the configuration command block
`timescale 1ns/1ps
module pmvc_chk
  import pmvc_pkg::*;
#(
  parameter logic [2:0] FMT_MODE = FMT_LINEAR,
  parameter logic [4:0] FMT_PARAM = 5'h17,
  parameter int FAULT_BITS = 8
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic CMD_VALID,
  input wire pmvc_cmd_t CMD,
  input wire logic RD_VALID,
  input wire logic [15:0] RD_DATA,
  input wire logic CMD_ERR,
  input wire logic CONFIG_READY,
  input wire logic [FAULT_BITS-1:0] FAULT_EVENT,
  input wire logic [FAULT_BITS-1:0] FAULT_STATUS,
  input wire logic [1:0] SECURITY_LEVEL,
  input wire logic TRANSITION_START,
  input wire logic [15:0] SLEW_RATE,
  input wire logic [15:0] DROOP_SLOPE,
  input wire logic [15:0] DUTY_LIMIT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  logic tk;
  logic wk;
  assign tk = CMD_VALID && CONFIG_READY;
  assign wk = tk && CMD.kind == PMVC_WRITE_WORD;
  property p_word(c, q);
    wk && CMD.code == c |=> q == $past(CMD.data);
  endproperty
  AST_CLEAR: assert property (
    tk && CMD.kind == PMVC_SEND_BYTE && CMD.code == CODE_CLEAR_FAULTS
    |=> FAULT_STATUS == $past(FAULT_EVENT)) else $error("fault clear");
  AST_FMT_RD: assert property (
    tk && CMD.kind == PMVC_READ_BYTE && CMD.code == CODE_FORMAT_MODE
    |=> RD_VALID && RD_DATA == {8'h00, FMT_MODE,
    ((FMT_MODE == FMT_DIRECT) ? FMT_DIRECT_PARAM : FMT_PARAM)})
    else $error("format byte");
  AST_FMT_RO: assert property (
    tk && CMD.code == CODE_FORMAT_MODE && CMD.kind != PMVC_READ_BYTE
    |=> CMD_ERR) else $error("format write taken");
  AST_EARLY: assert property (
    CMD_VALID && !CONFIG_READY |=> CMD_ERR) else $error("early command");
  AST_TRANS: assert property (
    wk && CMD.code == CODE_SETPOINT |=> TRANSITION_START)
    else $error("no transition");
  AST_SEC: assert property (
    tk && CMD.kind == PMVC_SEND_BYTE && CMD.code == CODE_RESTORE_USER
    |=> SECURITY_LEVEL == SEC_LEVEL1) else $error("security level");
  AST_PWRUP: assert property (
    $rose(CONFIG_READY) |-> SECURITY_LEVEL == SEC_LEVEL1)
    else $error("no power-up restore");
  AST_DUTY_NEG: assert property (
    wk && CMD.code == CODE_DUTY && CMD.data[LIN_MANT_MSB] |=> CMD_ERR)
    else $error("negative duty taken");
  AST_DUTY: assert property (
    wk && CMD.code == CODE_DUTY && CMD.data <= 16'h0064
    |=> DUTY_LIMIT == $past(CMD.data) && !CMD_ERR) else $error("duty");
  AST_SLEW: assert property (
    p_word(CODE_SLEW, SLEW_RATE)) else $error("slew");
  AST_DROOP: assert property (
    p_word(CODE_DROOP, DROOP_SLOPE)) else $error("droop");
  cover property (tk && CMD.code == CODE_RESTORE_USER);
  cover property (CMD_ERR);
  cover property (TRANSITION_START);
endmodule : pmvc_chk

bind pmvc_top pmvc_chk #(.FMT_MODE(FMT_MODE), .FMT_PARAM(FMT_PARAM),
  .FAULT_BITS(FAULT_BITS)) u_chk (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
  .CMD_VALID(CMD_VALID), .CMD(CMD), .RD_VALID(RD_VALID),
  .RD_DATA(RD_DATA), .CMD_ERR(CMD_ERR), .CONFIG_READY(CONFIG_READY),
  .FAULT_EVENT(FAULT_EVENT), .FAULT_STATUS(FAULT_STATUS),
  .SECURITY_LEVEL(SECURITY_LEVEL), .TRANSITION_START(TRANSITION_START),
  .SLEW_RATE(SLEW_RATE), .DROOP_SLOPE(DROOP_SLOPE),
  .DUTY_LIMIT(DUTY_LIMIT));

// File: verification/pmvc_host.sv
// Host model issuing configuration commands
`timescale 1ns/1ps
module pmvc_host
  import pmvc_pkg::*;
#(
  parameter int GAP = 8
) (
  input wire logic clk,
  output logic cmd_valid,
  output pmvc_cmd_t cmd,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic cmd_err
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // One command pulse, answer taken one edge later
  task automatic send(input pmvc_kind_t k, input logic [7:0] c,
      input logic [15:0] d, output logic err, output logic [15:0] q);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{kind: k, code: c, data: d};
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd <= pmvc_cmd_t'(~{k, c, d});
    #1;
    err = cmd_err;
    q = rd_valid ? rd_data : 16'hxxxx;
    // Settle time after user store or user restore, shortened
    if (k == PMVC_SEND_BYTE && c inside {CODE_STORE_USER,
        CODE_RESTORE_USER}) begin
      repeat (GAP) @(posedge clk);
    end
  endtask : send
endmodule : pmvc_host

// File: verification/pmvc_tb.sv
// Self-checking bench for the configuration command block
`timescale 1ns/1ps
module pmvc_tb
  import pmvc_pkg::*;
;
  localparam logic [4:0] FP = 5'h1c;
  logic clk, rst_n, store_rst_n, cmd_valid, rd_valid, cmd_err, ready, trans;
  logic err;
  pmvc_cmd_t cmd;
  logic [15:0] rd_data, strap, target, slew, droop, duty, q, ceil, d;
  logic [15:0] sp, mh, ml, tr, ca;
  logic [1:0] msel, sec;
  logic [7:0] fev, fst, f;
  int miscompares, n_tests, seed, i, m;

  pmvc_top #(.FMT_MODE(FMT_LINEAR), .FMT_PARAM(FP)) DUT (
    .CORE_CLK(clk), .RESETN(rst_n), .STORE_RESETN(store_rst_n),
    .CMD_VALID(cmd_valid), .CMD(cmd), .RD_VALID(rd_valid),
    .RD_DATA(rd_data), .CMD_ERR(cmd_err), .CONFIG_READY(ready),
    .VOLTAGE_SELECT_STRAP(strap), .MARGIN_SEL(msel), .FAULT_EVENT(fev),
    .FAULT_STATUS(fst), .SECURITY_LEVEL(sec), .TRANSITION_START(trans),
    .TARGET_VOLTAGE(target), .SLEW_RATE(slew), .DROOP_SLOPE(droop),
    .DUTY_LIMIT(duty));
  pmvc_host #(.GAP(8)) HOST (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd),
    .rd_valid(rd_valid), .rd_data(rd_data), .cmd_err(cmd_err));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_tgt(input logic [1:0] s);
    int v;
    v = (s == MARGIN_LOW) ? ml : (s == MARGIN_HIGH) ? mh : sp;
    v = v + $signed(tr) + $signed(ca);
    if (v < 0) v = 0;
    if (v > ceil) v = ceil;
    return 16'(v);
  endfunction : exp_tgt
  task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_w
  task automatic chk_b(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_b
  task automatic wr(input logic [7:0] c, input logic [15:0] v,
      input logic e);
    HOST.send(PMVC_WRITE_WORD, c, v, err, q);
    chk_b(err, e);
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    HOST.send(PMVC_READ_WORD, c, 16'h0000, err, q);
    chk_w(q, e);
  endtask : rd
  task automatic sb(input logic [7:0] c, input logic e);
    HOST.send(PMVC_SEND_BYTE, c, 16'h0000, err, q);
    chk_b(err, e);
  endtask : sb
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic do_reset(input logic early);
    int k;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    store_rst_n <= 1'b1;
    if (early) begin
      rd(CODE_SETPOINT, 16'hxxxx);
      chk_b(err, 1'b1);
    end
    for (k = 0; k < 20 && ready !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (ready !== 1'b1) begin
      miscompares++;
      conclude();
    end
    chk_w({14'h0000, sec}, {14'h0000, SEC_LEVEL1});
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h1ae6;
    rst_n = 1'b0;
    store_rst_n = 1'b0;
    msel = 2'h0;
    fev = 8'h00;
    strap = 16'h0400 | 16'($random(seed) & 32'h03ff);
    ceil = 16'(int'(strap) * 110 / 100);
    do_reset(1'b1);
    rd(CODE_SETPOINT, strap);
    rd(CODE_MARGIN_HIGH, strap);
    rd(CODE_MARGIN_LOW, strap);
    rd(CODE_CEILING, ceil);
    rd(CODE_CAL, 16'h0000);
    HOST.send(PMVC_READ_BYTE, CODE_FORMAT_MODE, 16'h0000, err, q);
    chk_w(q, {8'h00, FMT_LINEAR, FP});
    $display("test factory done");
    wr(CODE_FORMAT_MODE, 16'h0000, 1'b1);
    sb(CODE_SETPOINT, 1'b1);
    sb(8'h50, 1'b1);
    wr(CODE_CEILING, 16'hffff, 1'b0);
    rd(CODE_CEILING, ceil);
    wr(CODE_DUTY, 16'h0064, 1'b0);
    wr(CODE_DUTY, 16'h0065, 1'b1);
    wr(CODE_DUTY, 16'h0400, 1'b1);
    chk_w(duty, 16'h0064);
    // Negative exponent: 201 x 2^-1 is above the limit, 200 x 2^-1 is not
    wr(CODE_DUTY, 16'hf8c9, 1'b1);
    wr(CODE_DUTY, 16'hf8c8, 1'b0);
    chk_w(duty, 16'hf8c8);
    for (i = 0; i < 4; i++) begin
      d = 16'($random(seed));
      wr(CODE_SLEW, d, 1'b0);
      chk_w(slew, d);
      wr(CODE_DROOP, ~d, 1'b0);
      chk_w(droop, ~d);
    end
    $display("test refusals done");
    for (i = 0; i < 8; i++) begin
      sp = 16'($random(seed)) % ceil;
      mh = 16'($random(seed)) % ceil;
      ml = 16'($random(seed)) % ceil;
      tr = i[0] ? 16'($random(seed)) : 16'($random(seed) % 64);
      ca = 16'($random(seed) % 16);
      wr(CODE_SETPOINT, sp, 1'b0);
      chk_b(trans, 1'b1);
      wr(CODE_MARGIN_HIGH, mh, 1'b0);
      chk_b(trans, 1'b0);
      wr(CODE_MARGIN_LOW, ml, 1'b0);
      wr(CODE_TRIM, tr, 1'b0);
      wr(CODE_CAL, ca, 1'b0);
      for (m = 0; m < 4; m++) begin
        @(posedge clk);
        msel <= m[1:0];
        repeat (3) @(posedge clk);
        #1;
        chk_w(target, exp_tgt(m[1:0]));
      end
    end
    $display("test target done");
    f = 8'($random(seed)) | 8'h01;
    @(posedge clk);
    fev <= f;
    @(posedge clk);
    fev <= 8'h00;
    #1;
    chk_w({8'h00, fst}, {8'h00, f});
    sb(CODE_CLEAR_FAULTS, 1'b0);
    chk_w({8'h00, fst}, 16'h0000);
    $display("test faults done");
    sb(CODE_STORE_DEFAULT, 1'b0);
    wr(CODE_SETPOINT, 16'h0001, 1'b0);
    sb(CODE_RESTORE_DEFAULT, 1'b0);
    rd(CODE_SETPOINT, sp);
    sb(CODE_RESTORE_USER, 1'b0);
    wr(CODE_MARGIN_HIGH, 16'h0011, 1'b0);
    sb(CODE_STORE_USER, 1'b0);
    wr(CODE_MARGIN_HIGH, 16'h0022, 1'b0);
    sb(CODE_RESTORE_DEFAULT, 1'b0);
    rd(CODE_MARGIN_HIGH, mh);
    sb(CODE_RESTORE_USER, 1'b0);
    rd(CODE_MARGIN_HIGH, 16'h0011);
    rd(CODE_SETPOINT, sp);
    do_reset(1'b0);
    rd(CODE_MARGIN_HIGH, 16'h0011);
    $display("test stores done");
    conclude();
  end
endmodule : pmvc_tb
